// ### bsla_core.sv
// Accumulator datapath: instruction decode, operand sequencing and write-back
// How it works
// - Register field: B0 C1 D2 E3 H4 L5 A7
// - Subtract opcodes 10010rrr, D6, 96, prefixed 96
// - Borrow subtract 10011rrr, DE, 9E, prefixed 9E
// - AND opcodes 10100rrr, E6, A6, prefixed A6
// - OR opcodes 10110rrr, F6, B6, prefixed B6
// - Subtract operand from accumulator, store difference
// - Borrow subtract also removes carry_in
// - AND accumulator with operand, store
// - OR accumulator with operand, store
// - Register 4 states; immediate, pointer 4+3
// - Indexed forms take 4,4,3,5,3 states
// - Sign and zero follow the result
// - Subtracts: half borrow from bit 4, indicator set
// - Subtracts: carry means borrow out of byte
// - Subtract overflow sets parity_overflow flag
// - Borrow subtract, AND: overflow flag reading ambiguous
// - AND: half set, indicator, carry cleared
// - OR: half, indicator, carry all cleared
// - Index plus signed displacement forms address
`timescale 1ns/1ps
`include "bsla_params.svh"

module bsla_core (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [15:0] i_pc,
  input wire logic i_load,
  input wire logic [7:0] i_load_acc,
  input wire logic [7:0] i_load_flags,
  input wire logic [7:0] i_reg_b,
  input wire logic [7:0] i_reg_c,
  input wire logic [7:0] i_reg_d,
  input wire logic [7:0] i_reg_e,
  input wire logic [7:0] i_reg_h,
  input wire logic [7:0] i_reg_l,
  input wire logic [15:0] i_index_x,
  input wire logic [15:0] i_index_y,
  input wire logic [7:0] i_mem_data,
  output logic [15:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [15:0] o_next_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_flags
);

  // Operation field of an opcode byte is one of the four groups
  function automatic logic grp_ok(input logic [7:0] op);
    grp_ok = (op[5:3] == `BSLA_GRP_SUB) || (op[5:3] == `BSLA_GRP_SUBB) ||
             (op[5:3] == `BSLA_GRP_AND) || (op[5:3] == `BSLA_GRP_OR);
  endfunction

  // Map the operation field onto a group
  function automatic bsla_pkg::bsla_group_type grp_of(input logic [7:0] op);
    case (op[5:3])
      `BSLA_GRP_SUB: grp_of = bsla_pkg::GRP_SUB;
      `BSLA_GRP_SUBB: grp_of = bsla_pkg::GRP_SUBB;
      `BSLA_GRP_AND: grp_of = bsla_pkg::GRP_AND;
      default: grp_of = bsla_pkg::GRP_OR;
    endcase
  endfunction

  // Operand form of an opcode byte; used for first and post-prefix bytes
  function automatic bsla_pkg::bsla_form_type form_of(input logic [7:0] op);
    if (!grp_ok(op)) begin
      form_of = bsla_pkg::FORM_BAD;
    end else if (op[7:6] == `BSLA_CLASS_REG) begin
      form_of = (op[2:0] == `BSLA_REG_MEM) ? bsla_pkg::FORM_PTR : bsla_pkg::FORM_REG;
    end else if ((op[7:6] == `BSLA_CLASS_IMM) && (op[2:0] == `BSLA_REG_MEM)) begin
      form_of = bsla_pkg::FORM_IMM;
    end else begin
      form_of = bsla_pkg::FORM_BAD;
    end
  endfunction

  // Machine cycle length in clock states for each sequencing state
  function automatic logic [2:0] mc_len(input bsla_pkg::bsla_state_type st);
    case (st)
      bsla_pkg::ST_FETCH_OP: mc_len = `BSLA_T_FETCH;
      bsla_pkg::ST_FETCH_IDX_OP: mc_len = `BSLA_T_FETCH;
      bsla_pkg::ST_CALC: mc_len = `BSLA_T_CALC;
      default: mc_len = `BSLA_T_READ;
    endcase
  endfunction

  // Sequencer state and the instruction held across machine cycles
  bsla_pkg::bsla_state_type state;
  bsla_pkg::bsla_group_type group;
  bsla_pkg::bsla_form_type form;
  logic [2:0] tcnt;
  logic [15:0] pc;
  logic use_y;
  logic [7:0] disp;

  // Decode and operand nets
  wire mc_last;
  wire [15:0] pc_inc;
  wire is_prefix;
  wire bsla_pkg::bsla_form_type byte_form;
  wire [7:0] reg_operand;
  wire [15:0] index_base;
  wire [15:0] index_addr;
  wire [15:0] pointer_addr;
  wire bsla_pkg::bsla_group_type alu_group;
  wire [7:0] alu_operand;
  wire [7:0] alu_result;
  wire [7:0] alu_flags;

  // Completion and write-back nets
  wire finish_reg;
  wire finish_opnd;
  wire finish_bad;
  wire finish_any;
  wire [15:0] next_pc_val;
  wire load_take;
  wire acc_write;
  wire [7:0] next_acc;
  wire [7:0] next_flags;

  // Decode of the byte arriving on the memory bus
  assign mc_last = (tcnt == (mc_len(state) - 3'h1));
  assign pc_inc = pc + 16'h0001;
  assign is_prefix = (i_mem_data == `BSLA_PFX_X) || (i_mem_data == `BSLA_PFX_Y);
  assign byte_form = form_of(i_mem_data);
  assign pointer_addr = {i_reg_h, i_reg_l};

  // Register operand select; code 110 never reaches here as it is the pointer form
  assign reg_operand = (i_mem_data[2:0] == `BSLA_REG_B) ? i_reg_b :
                       (i_mem_data[2:0] == `BSLA_REG_C) ? i_reg_c :
                       (i_mem_data[2:0] == `BSLA_REG_D) ? i_reg_d :
                       (i_mem_data[2:0] == `BSLA_REG_E) ? i_reg_e :
                       (i_mem_data[2:0] == `BSLA_REG_H) ? i_reg_h :
                       (i_mem_data[2:0] == `BSLA_REG_L) ? i_reg_l : o_acc;

  // Displacement is sign extended before the add
  assign index_base = use_y ? i_index_y : i_index_x;
  assign index_addr = index_base + {{8{disp[7]}}, disp};

  // Register form executes straight off the opcode byte
  assign alu_group = (state == bsla_pkg::ST_FETCH_OP) ? grp_of(i_mem_data) : group;
  assign alu_operand = (state == bsla_pkg::ST_FETCH_OP) ? reg_operand : i_mem_data;

  // Completion decode: register form, operand read, or an opcode with no legal form in the four groups or not pointer-style after a prefix
  assign finish_reg = (state == bsla_pkg::ST_FETCH_OP) && mc_last && !is_prefix &&
                      (byte_form == bsla_pkg::FORM_REG);
  assign finish_opnd = (state == bsla_pkg::ST_READ_OPND) && mc_last;
  assign finish_bad = ((state == bsla_pkg::ST_FETCH_OP) && mc_last && !is_prefix &&
                       (byte_form == bsla_pkg::FORM_BAD)) ||
                      ((state == bsla_pkg::ST_FETCH_IDX_OP) && mc_last &&
                       (byte_form != bsla_pkg::FORM_PTR));
  assign finish_any = finish_reg || finish_opnd || finish_bad;
  // Immediate form still owes its operand byte; the other reads already point past their bytes
  assign next_pc_val = (finish_opnd && (form != bsla_pkg::FORM_IMM)) ? pc : pc_inc;

  // Start wins over a load in the same cycle; a load while busy is dropped
  assign load_take = (state == bsla_pkg::ST_IDLE) && !i_start && i_load;
  // Foreign opcodes never reach the accumulator or the flags
  assign acc_write = finish_reg || finish_opnd;
  assign next_acc = acc_write ? alu_result : i_load_acc;
  assign next_flags = acc_write ? alu_flags : i_load_flags;

  bsla_alu bsla_alu_inst (
    .i_acc(o_acc),
    .i_operand(alu_operand),
    .i_carry_in(o_flags[`BSLA_F_CARRY]),
    .i_group(alu_group),
    .o_result(alu_result),
    .o_flags(alu_flags)
  );

  // Sequencer: every machine cycle runs tcnt up to its length, bus byte taken on the last state of each cycle except ST_CALC
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= bsla_pkg::ST_IDLE;
      group <= bsla_pkg::GRP_SUB;
      form <= bsla_pkg::FORM_REG;
      tcnt <= 3'h0;
      pc <= `BSLA_PC_RST;
      use_y <= 1'b0;
      disp <= 8'h00;
      o_mem_addr <= `BSLA_PC_RST;
      o_mem_rd <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      tcnt <= mc_last ? 3'h0 : tcnt + 3'h1;
      case (state)
        bsla_pkg::ST_IDLE: begin
          // Counter parked while idle so every fetch starts at state zero
          tcnt <= 3'h0;
          if (i_start) begin
            pc <= i_pc;
            o_mem_addr <= i_pc;
            o_mem_rd <= 1'b1;
            o_busy <= 1'b1;
            state <= bsla_pkg::ST_FETCH_OP;
          end
        end
        bsla_pkg::ST_FETCH_OP: begin
          if (mc_last) begin
            pc <= pc_inc;
            group <= grp_of(i_mem_data);
            form <= byte_form;
            if (is_prefix) begin
              use_y <= (i_mem_data == `BSLA_PFX_Y);
              o_mem_addr <= pc_inc;
              state <= bsla_pkg::ST_FETCH_IDX_OP;
            end else if (byte_form == bsla_pkg::FORM_REG) begin
              o_mem_rd <= 1'b0;
              o_busy <= 1'b0;
              state <= bsla_pkg::ST_IDLE;
            end else if (byte_form == bsla_pkg::FORM_IMM) begin
              o_mem_addr <= pc_inc;
              state <= bsla_pkg::ST_READ_OPND;
            end else if (byte_form == bsla_pkg::FORM_PTR) begin
              o_mem_addr <= pointer_addr;
              state <= bsla_pkg::ST_READ_OPND;
            end else begin
              // No legal form in the four groups: done with illegal, nothing written
              o_mem_rd <= 1'b0;
              o_busy <= 1'b0;
              state <= bsla_pkg::ST_IDLE;
            end
          end
        end
        bsla_pkg::ST_FETCH_IDX_OP: begin
          if (mc_last) begin
            pc <= pc_inc;
            group <= grp_of(i_mem_data);
            // Only the pointer-style opcode is legal after a prefix
            if (byte_form == bsla_pkg::FORM_PTR) begin
              o_mem_addr <= pc_inc;
              state <= bsla_pkg::ST_READ_DISP;
            end else begin
              o_mem_rd <= 1'b0;
              o_busy <= 1'b0;
              state <= bsla_pkg::ST_IDLE;
            end
          end
        end
        bsla_pkg::ST_READ_DISP: begin
          if (mc_last) begin
            pc <= pc_inc;
            disp <= i_mem_data;
            o_mem_rd <= 1'b0;
            state <= bsla_pkg::ST_CALC;
          end
        end
        bsla_pkg::ST_CALC: begin
          // Bus idle while the address is formed
          if (mc_last) begin
            o_mem_addr <= index_addr;
            o_mem_rd <= 1'b1;
            state <= bsla_pkg::ST_READ_OPND;
          end
        end
        bsla_pkg::ST_READ_OPND: begin
          // Operand on the bus now; write-back happens in its own process
          if (mc_last) begin
            pc <= (form == bsla_pkg::FORM_IMM) ? pc_inc : pc;
            o_mem_rd <= 1'b0;
            o_busy <= 1'b0;
            state <= bsla_pkg::ST_IDLE;
          end
        end
        default: begin
          o_mem_rd <= 1'b0;
          o_busy <= 1'b0;
          state <= bsla_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Accumulator and flags; a load seeds the carry ahead of a borrow subtract
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= `BSLA_ACC_RST;
      o_flags <= `BSLA_FLAGS_RST;
    end else if (acc_write || load_take) begin
      o_acc <= next_acc;
      o_flags <= next_flags;
    end
  end

  // Completion outputs; illegal rides with the done pulse and drops the cycle after
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_next_pc <= `BSLA_PC_RST;
    end else begin
      o_done <= finish_any;
      o_illegal <= finish_bad;
      if (finish_any) begin
        o_next_pc <= next_pc_val;
      end
    end
  end

endmodule

// ### bsla_params.svh
// Constants for the byte subtract and logic accumulator datapath
`ifndef BSLA_PARAMS_SVH
`define BSLA_PARAMS_SVH

// Register-select field codes
`define BSLA_REG_B 3'h0
`define BSLA_REG_C 3'h1
`define BSLA_REG_D 3'h2
`define BSLA_REG_E 3'h3
`define BSLA_REG_H 3'h4
`define BSLA_REG_L 3'h5
`define BSLA_REG_MEM 3'h6
`define BSLA_REG_A 3'h7

// Operation field, bits 5:3 of the opcode
`define BSLA_GRP_SUB 3'h2
`define BSLA_GRP_SUBB 3'h3
`define BSLA_GRP_AND 3'h4
`define BSLA_GRP_OR 3'h6

// Opcode class, bits 7:6, and index prefixes
`define BSLA_CLASS_REG 2'h2
`define BSLA_CLASS_IMM 2'h3
`define BSLA_PFX_X 8'hDD
`define BSLA_PFX_Y 8'hFD

// Clock states per machine cycle, one clock state per reference clock
`define BSLA_T_FETCH 3'h4
`define BSLA_T_READ 3'h3
`define BSLA_T_CALC 3'h5

// Flag byte bit positions
`define BSLA_F_SIGN 7
`define BSLA_F_ZERO 6
`define BSLA_F_HALF 4
`define BSLA_F_PV 2
`define BSLA_F_SUBIND 1
`define BSLA_F_CARRY 0

// Reset values
`define BSLA_ACC_RST 8'h00
`define BSLA_FLAGS_RST 8'h00
`define BSLA_PC_RST 16'h0000

`endif

// ### bsla_pkg.sv
// Types shared by the accumulator datapath files
package bsla_pkg;
  typedef enum logic [1:0] {GRP_SUB, GRP_SUBB, GRP_AND, GRP_OR} bsla_group_type;
  typedef enum logic [1:0] {FORM_REG, FORM_IMM, FORM_PTR, FORM_BAD} bsla_form_type;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH_OP, ST_FETCH_IDX_OP, ST_READ_DISP, ST_CALC, ST_READ_OPND}
    bsla_state_type;
endpackage

// ### bsla_alu.sv
// Combinational result and flag generation for the four operation groups
`timescale 1ns/1ps
`include "bsla_params.svh"

module bsla_alu (
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic i_carry_in,
  input wire bsla_pkg::bsla_group_type i_group,
  output logic [7:0] o_result,
  output logic [7:0] o_flags
);

  logic borrow_in;
  logic [8:0] diff;
  logic [4:0] half_diff;
  logic is_sub;
  logic overflow;

  // Borrow only enters for the borrow variant
  assign is_sub = (i_group == bsla_pkg::GRP_SUB) || (i_group == bsla_pkg::GRP_SUBB);
  assign borrow_in = (i_group == bsla_pkg::GRP_SUBB) ? i_carry_in : 1'b0;
  assign diff = {1'b0, i_acc} - {1'b0, i_operand} - {8'h00, borrow_in};
  assign half_diff = {1'b0, i_acc[3:0]} - {1'b0, i_operand[3:0]} - {4'h0, borrow_in};
  // Opposite signs in and a result sign unlike the accumulator's
  assign overflow = (i_acc[7] ^ i_operand[7]) & (diff[7] ^ i_acc[7]);

  // Result select
  always_comb begin
    case (i_group)
      bsla_pkg::GRP_AND: o_result = i_acc & i_operand;
      bsla_pkg::GRP_OR: o_result = i_acc | i_operand;
      default: o_result = diff[7:0];
    endcase
  end

  // Flags; logic ops cannot overflow, so their overflow flag is always clear
  always_comb begin
    o_flags = 8'h00;
    o_flags[`BSLA_F_SIGN] = o_result[7];
    o_flags[`BSLA_F_ZERO] = (o_result == 8'h00);
    o_flags[`BSLA_F_HALF] = is_sub ? half_diff[4] : (i_group == bsla_pkg::GRP_AND);
    o_flags[`BSLA_F_PV] = is_sub ? overflow : 1'b0;
    o_flags[`BSLA_F_SUBIND] = is_sub;
    o_flags[`BSLA_F_CARRY] = is_sub ? diff[8] : 1'b0;
  end

endmodule

// ### bsla_properties.sv
// Timing and flag assertions for the accumulator datapath
`timescale 1ns/1ps
module bsla_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic [15:0] o_next_pc,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_flags
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Start is only accepted when idle
  wire taken = i_start && !o_busy;
  wire legal = o_done && !o_illegal;
  sequence s_fetch;
    o_mem_rd [*4];
  endsequence
  sequence s_idx_tail;
    (!o_mem_rd && o_busy) [*5] ##1 o_mem_rd [*3] ##1 o_done;
  endsequence
  property p_fetch_addr;
    taken |=> o_busy && o_mem_addr == $past(i_pc);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
  property p_fetch_len;
    taken |=> s_fetch;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("opcode fetch not 4 states");
  property p_done_min;
    taken |=> (!o_done) [*4];
  endproperty
  a_done_min: assert property (p_done_min) else $error("done too early");
  property p_done_max;
    taken |-> ##[5:20] o_done;
  endproperty
  a_done_max: assert property (p_done_max) else $error("done too late");
  property p_idx_tail;
    $fell(o_mem_rd) && o_busy |-> s_idx_tail;
  endproperty
  a_idx_tail: assert property (p_idx_tail) else $error("indexed tail not 5 then 3");
  property p_reg_pc;
    taken ##1 o_busy [*4] ##1 legal |-> o_next_pc == $past(i_pc, 5) + 16'h0001;
  endproperty
  a_reg_pc: assert property (p_reg_pc) else $error("register form length wrong");
  // Busy cycles since the start was taken; too long a run for a repetition
  logic [4:0] busy_len;
  logic [15:0] start_pc;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_len <= 5'h00;
      start_pc <= 16'h0000;
    end else if (taken) begin
      busy_len <= 5'h00;
      start_pc <= i_pc;
    end else if (o_busy) begin
      busy_len <= busy_len + 5'h01;
    end
  end
  property p_len;
    legal |-> busy_len == 5'h04 || busy_len == 5'h07 || busy_len == 5'h13;
  endproperty
  a_len: assert property (p_len) else $error("instruction length not 4, 7 or 19 states");
  property p_idx_pc;
    legal && busy_len == 5'h13 |-> o_next_pc == start_pc + 16'h0003;
  endproperty
  a_idx_pc: assert property (p_idx_pc) else $error("indexed form length wrong");
  property p_sz;
    legal |-> o_flags[7] == o_acc[7] && o_flags[6] == (o_acc == 8'h00);
  endproperty
  a_sz: assert property (p_sz) else $error("sign or zero flag wrong");
  property p_logic_cy;
    legal && !o_flags[1] |-> !o_flags[0] && !o_flags[2];
  endproperty
  a_logic_cy: assert property (p_logic_cy) else $error("logic op carry set");
endmodule

bind bsla_core bsla_props bsla_props_inst (.i_ref_clk, .i_rst_n, .i_start, .i_pc, .o_mem_addr, .o_mem_rd,
  .o_busy, .o_done, .o_illegal, .o_next_pc, .o_acc, .o_flags);

// ### bsla_mem.sv
// Behavioural memory answering the datapath's read cycles
`timescale 1ns/1ps
module bsla_mem (
  input wire logic i_ref_clk,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h5A;
  // Released bus shows the inverse of the last byte, so stale data never passes
  always @(posedge i_ref_clk) begin
    if (i_rd) begin
      last <= o_data;
    end
  end
  always_comb begin
    o_data = i_rd ? mem[i_addr] : ~last;
  end
endmodule

// ### bsla_core_tb.sv
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ps
module bsla_core_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_load = 1'b0;
  logic [15:0] i_pc = 16'h0000;
  logic [7:0] i_load_acc = 8'h00;
  logic [7:0] i_load_flags = 8'h00;
  logic [7:0] regs [0:5] = '{8'h3C, 8'h81, 8'h11, 8'h7F, 8'h12, 8'h34};
  logic [7:0] base [0:3] = '{8'h90, 8'h98, 8'hA0, 8'hB0};
  logic [15:0] i_index_x = 16'h1200;
  logic [15:0] i_index_y = 16'h2300;
  logic [7:0] i_mem_data;
  logic [15:0] o_mem_addr;
  logic [15:0] o_next_pc;
  logic [7:0] o_acc;
  logic [7:0] o_flags;
  logic o_mem_rd;
  logic o_busy;
  logic o_done;
  logic o_illegal;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  bsla_core bsla_core_inst (.i_ref_clk, .i_rst_n, .i_start, .i_pc, .i_load, .i_load_acc, .i_load_flags,
    .i_reg_b(regs[0]), .i_reg_c(regs[1]), .i_reg_d(regs[2]), .i_reg_e(regs[3]), .i_reg_h(regs[4]),
    .i_reg_l(regs[5]), .i_index_x, .i_index_y, .i_mem_data, .o_mem_addr, .o_mem_rd, .o_busy, .o_done,
    .o_illegal, .o_next_pc, .o_acc, .o_flags);
  bsla_mem bsla_mem_inst (.i_ref_clk, .i_rd(o_mem_rd), .i_addr(o_mem_addr), .o_data(i_mem_data));

  // Clock and a hang guard well above the longest sequence
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reference result and flags; group 0 sub, 1 borrow sub, 2 and, 3 or
  function automatic logic [15:0] model(input logic [1:0] g, input logic [7:0] a, input logic [7:0] b,
    input logic c);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] f;
    d = {1'b0, a} - {1'b0, b} - {8'h00, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    r = (g == 2'h2) ? (a & b) : (g == 2'h3) ? (a | b) : d[7:0];
    if (g < 2'h2) begin
      f = {r[7], r == 8'h00, 1'b0, h[4], 1'b0, (a[7] != b[7]) && (r[7] != a[7]), 1'b1, d[8]};
    end else begin
      f = {r[7], r == 8'h00, 1'b0, g == 2'h2, 4'h0};
    end
    return {r, f};
  endfunction

  task load(input logic [7:0] a, input logic [7:0] f);
    @(negedge i_ref_clk);
    i_load_acc = a;
    i_load_flags = f;
    i_load = 1'b1;
    @(negedge i_ref_clk);
    i_load = 1'b0;
  endtask

  // Starts at a falling edge, counts clock states up to the done pulse
  task run(input logic [15:0] pc, input int lat, input logic [15:0] exp, input logic [15:0] adv);
    int n;
    n = 0;
    i_pc = pc;
    i_start = 1'b1;
    do begin
      @(negedge i_ref_clk);
      i_start = 1'b0;
      n++;
    end while (o_done !== 1'b1 && n < 30);
    chk("cycles", n[15:0], lat[15:0]);
    chk("acc_flags", {o_acc, o_flags}, exp);
    if (adv != 16'h0000) begin
      chk("next_pc", o_next_pc, pc + adv);
    end
  endtask

  task s_reg();
    for (int r = 0; r < 8; r++) begin
      if (r != 6) begin
        load(8'h29, 8'h00);
        bsla_mem_inst.mem[16'h0100] = 8'h90 | r[7:0];
        run(16'h0100, 5, model(2'h0, 8'h29, (r == 7) ? 8'h29 : regs[r], 1'b0), 16'h0001);
      end
    end
  endtask

  // Boundary operands: signed overflow, half borrow and full borrow, both carry inputs
  task s_imm();
    logic [7:0] b;
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 4; k++) begin
        b = k[1] ? 8'h90 : 8'h01;
        load(8'h80, {7'h00, k[0]});
        bsla_mem_inst.mem[16'h0200] = base[g] + 8'h46;
        bsla_mem_inst.mem[16'h0201] = b;
        run(16'h0200, 8, model(g[1:0], 8'h80, b, g == 1 && k[0]), 16'h0002);
      end
    end
  endtask

  task s_ptr();
    for (int g = 0; g < 4; g++) begin
      load(8'h5A, 8'h01);
      bsla_mem_inst.mem[16'h1234] = 8'hA5;
      bsla_mem_inst.mem[16'h0300] = base[g] | 8'h06;
      run(16'h0300, 8, model(g[1:0], 8'h5A, 8'hA5, g == 1), 16'h0001);
    end
  endtask

  // Negative displacement on both index registers
  task s_idx();
    for (int k = 0; k < 2; k++) begin
      for (int g = 0; g < 4; g++) begin
        load(8'h0F, 8'h00);
        bsla_mem_inst.mem[16'h0400] = k[0] ? 8'hFD : 8'hDD;
        bsla_mem_inst.mem[16'h0401] = base[g] | 8'h06;
        bsla_mem_inst.mem[16'h0402] = 8'hFE;
        bsla_mem_inst.mem[k[0] ? 16'h22FE : 16'h11FE] = 8'h10;
        run(16'h0400, 20, model(g[1:0], 8'h0F, 8'h10, 1'b0), 16'h0003);
      end
    end
  endtask

  // Back-to-back foreign opcodes leave accumulator and flags alone
  task s_bad();
    load(8'h33, 8'h44);
    bsla_mem_inst.mem[16'h0500] = 8'h80;
    bsla_mem_inst.mem[16'h0600] = 8'hDD;
    bsla_mem_inst.mem[16'h0601] = 8'h86;
    run(16'h0500, 5, 16'h3344, 16'h0000);
    chk("illegal", {15'h0000, o_illegal}, 16'h0001);
    run(16'h0600, 9, 16'h3344, 16'h0000);
    chk("illegal_idx", {15'h0000, o_illegal}, 16'h0001);
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    s_reg();
    s_imm();
    s_ptr();
    s_idx();
    s_bad();
    stop_test();
  end
endmodule
